// [hdl/cwb_req_gen.v]
// Functional notes
// - Written bytes stay inside one cache line
// - Partial line updates are allowed
// - Wrap start aligned to bus-wide size
// - Wrap length only 2, 4, 8, 16
// - Wrap size times length within line
// - Incrementing bursts at most 16 beats
// - Incrementing last byte in first line
// - Write-backs never use System domain
// - Protection and QoS pass through freely
// - Any strobe pattern, sparse included
// - True domain given for snoop filter
// - Non, inner or outer shareable allowed
// - Barrier marked by barrier attribute bit0
// - Barrier: INCR, zero address, length, snoop
// - Barrier size equals full bus width
// - Barrier cache is normal non-cacheable
// - Barrier may carry any domain
`timescale 1ns/1ps
`include "cwb_req_map.vh"

module cwb_req_gen (
  // Clock and reset
  input  wire                     ref_clk,
  input  wire                     rst,
  // Command port
  input  wire                     cmd_valid,
  output reg                      cmd_ready_ff,
  input  wire [1:0]               cmd_op,
  input  wire [`CWB_ADDR_W-1:0]   cmd_addr,
  input  wire [4:0]               cmd_beats,
  input  wire                     cmd_wrap,
  input  wire [1:0]               cmd_domain,
  input  wire [3:0]               cmd_cache,
  input  wire [2:0]               cmd_prot,
  input  wire [3:0]               cmd_qos,
  output reg                      cmd_err_ff,
  output reg  [1:0]               cmd_err_code_ff,
  // Write beat port
  input  wire                     wr_valid,
  output reg                      wr_ready_ff,
  input  wire [`CWB_DATA_W-1:0]   wr_data,
  input  wire [`CWB_STRB_W-1:0]   wr_strb,
  // Write address channel
  output reg                      aw_valid_ff,
  input  wire                     aw_ready,
  output reg  [`CWB_ADDR_W-1:0]   aw_addr_ff,
  output reg  [1:0]               aw_burst_ff,
  output reg  [7:0]               aw_len_ff,
  output reg  [2:0]               aw_size_ff,
  output reg  [2:0]               aw_snoop_ff,
  output reg  [1:0]               aw_domain_ff,
  output reg  [1:0]               aw_bar_ff,
  output reg  [3:0]               aw_cache_ff,
  output reg                      aw_lock_ff,
  output reg  [2:0]               aw_prot_ff,
  output reg  [3:0]               aw_qos_ff,
  // Write data channel
  output reg                      w_valid_ff,
  input  wire                     w_ready,
  output reg  [`CWB_DATA_W-1:0]   w_data_ff,
  output reg  [`CWB_STRB_W-1:0]   w_strb_ff,
  output reg                      w_last_ff,
  // Read address channel
  output reg                      ar_valid_ff,
  input  wire                     ar_ready,
  output reg  [`CWB_ADDR_W-1:0]   ar_addr_ff,
  output reg  [1:0]               ar_burst_ff,
  output reg  [7:0]               ar_len_ff,
  output reg  [2:0]               ar_size_ff,
  output reg  [3:0]               ar_snoop_ff,
  output reg  [1:0]               ar_domain_ff,
  output reg  [1:0]               ar_bar_ff,
  output reg  [3:0]               ar_cache_ff,
  output reg                      ar_lock_ff,
  output reg  [2:0]               ar_prot_ff
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_AW   = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  localparam [1:0] ST_AR   = 2'h3;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [4:0] beats_ff;
  reg  [4:0] beat_cnt_ff;
  reg        has_data_ff;

  wire       cmd_take;
  wire       is_write_line;
  wire [4:0] start_beat;
  wire [5:0] end_beat;
  wire       len_pow2;
  wire       wrap_ok;
  wire       incr_ok;
  wire       dom_ok;
  wire       w_take;
  wire       w_done;
  reg  [1:0] err_code;

  assign cmd_take      = cmd_valid & cmd_ready_ff;
  assign is_write_line = (cmd_op == `CWB_OP_WB) | (cmd_op == `CWB_OP_WC);

  // Beat index of the start inside its cache line
  assign start_beat = {2'h0, cmd_addr[`CWB_BEAT_MSB:`CWB_BEAT_LSB]};
  assign end_beat   = {1'h0, start_beat} + {1'h0, cmd_beats};

  // Wrap length check: power-of-two beats, whole burst inside a line
  assign len_pow2 = (cmd_beats == 5'h02) | (cmd_beats == 5'h04) |
                    (cmd_beats == 5'h08) | (cmd_beats == 5'h10);
  assign wrap_ok  = len_pow2 & (cmd_beats <= `CWB_LINE_BEATS);

  // Incrementing: last bus-wide beat must still be in the first line
  assign incr_ok = (cmd_beats != 5'h00) & (cmd_beats <= `CWB_MAX_BEATS) &
                   (end_beat <= {1'h0, `CWB_LINE_BEATS});

  // System domain refused for write-lines; the given domain is otherwise never altered
  assign dom_ok = (cmd_domain != `CWB_DOM_SYS);

  // Classify a write-back or write-clean command
  always @* begin
    err_code = `CWB_ERR_NONE;
    if (is_write_line) begin
      if (!dom_ok) begin
        err_code = `CWB_ERR_DOMAIN;
      end else if (cmd_wrap && !len_pow2) begin
        err_code = `CWB_ERR_LENGTH;
      end else if (cmd_wrap && !wrap_ok) begin
        err_code = `CWB_ERR_LINE;
      end else if (!cmd_wrap && ((cmd_beats == 5'h00) || (cmd_beats > `CWB_MAX_BEATS))) begin
        err_code = `CWB_ERR_LENGTH;
      end else if (!cmd_wrap && !incr_ok) begin
        err_code = `CWB_ERR_LINE;
      end
    end
  end

  // Write beat hand-off through a single holding slot
  assign w_take = wr_valid & wr_ready_ff;
  assign w_done = w_valid_ff & w_ready & w_last_ff;

  // Next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cmd_take && (err_code == `CWB_ERR_NONE)) begin
          nxt_state = (cmd_op == `CWB_OP_BAR_RD) ? ST_AR : ST_AW;
        end
      end
      ST_AW: begin
        if (aw_ready) begin
          nxt_state = has_data_ff ? ST_DATA : ST_IDLE;
        end
      end
      ST_DATA: begin
        if (w_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_AR: begin
        if (ar_ready) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Control state, command ready and error pulse
  always @(posedge ref_clk) begin
    if (rst) begin
      state_ff        <= ST_IDLE;
      cmd_ready_ff    <= 1'h0;
      cmd_err_ff      <= 1'h0;
      cmd_err_code_ff <= `CWB_ERR_NONE;
      beats_ff        <= 5'h00;
      has_data_ff     <= 1'h0;
    end else begin
      state_ff   <= nxt_state;
      // Ready drops on take so a second command cannot slip in
      cmd_ready_ff <= (nxt_state == ST_IDLE) & ~cmd_take;
      cmd_err_ff <= cmd_take & (err_code != `CWB_ERR_NONE);
      if (cmd_take) begin
        cmd_err_code_ff <= err_code;
        beats_ff        <= cmd_beats;
        has_data_ff     <= is_write_line;
      end
    end
  end

  // Write address channel
  always @(posedge ref_clk) begin
    if (rst) begin
      aw_valid_ff  <= 1'h0;
      aw_addr_ff   <= {`CWB_ADDR_W{1'b0}};
      aw_burst_ff  <= `CWB_BURST_INCR;
      aw_len_ff    <= 8'h00;
      aw_size_ff   <= `CWB_SIZE_BUS;
      aw_snoop_ff  <= `CWB_SNP_ZERO;
      aw_domain_ff <= `CWB_DOM_NSH;
      aw_bar_ff    <= `CWB_BAR_NORMAL;
      aw_cache_ff  <= `CWB_CACHE_BAR;
      aw_lock_ff   <= `CWB_LOCK_NORMAL;
      aw_prot_ff   <= 3'h0;
      aw_qos_ff    <= 4'h0;
    end else begin
      if (aw_valid_ff && aw_ready) begin
        aw_valid_ff <= 1'h0;
      end
      if (cmd_take && (err_code == `CWB_ERR_NONE) && (cmd_op != `CWB_OP_BAR_RD)) begin
        aw_valid_ff  <= 1'h1;
        aw_size_ff   <= `CWB_SIZE_BUS;
        aw_lock_ff   <= `CWB_LOCK_NORMAL;
        aw_prot_ff   <= cmd_prot;
        aw_qos_ff    <= cmd_qos;
        aw_domain_ff <= cmd_domain;
        if (is_write_line) begin
          // Low bits cleared: start always aligned to the bus-wide size
          aw_addr_ff  <= {cmd_addr[`CWB_ADDR_W-1:`CWB_BEAT_LSB],
                          {`CWB_BEAT_LSB{1'b0}}};
          aw_burst_ff <= cmd_wrap ? `CWB_BURST_WRAP : `CWB_BURST_INCR;
          aw_len_ff   <= {3'h0, cmd_beats - 5'h01};
          aw_snoop_ff <= (cmd_op == `CWB_OP_WB) ? `CWB_SNP_WB : `CWB_SNP_WC;
          aw_bar_ff   <= `CWB_BAR_NORMAL;
          aw_cache_ff <= cmd_cache | `CWB_CACHE_MOD;
        end else begin
          aw_addr_ff  <= {`CWB_ADDR_W{1'b0}};
          aw_burst_ff <= `CWB_BURST_INCR;
          aw_len_ff   <= 8'h00;
          aw_snoop_ff <= `CWB_SNP_ZERO;
          aw_bar_ff   <= `CWB_BAR_BARRIER;
          aw_cache_ff <= `CWB_CACHE_BAR;
        end
      end
    end
  end

  // Read address channel carries only read barriers
  always @(posedge ref_clk) begin
    if (rst) begin
      ar_valid_ff  <= 1'h0;
      ar_addr_ff   <= {`CWB_ADDR_W{1'b0}};
      ar_burst_ff  <= `CWB_BURST_INCR;
      ar_len_ff    <= 8'h00;
      ar_size_ff   <= `CWB_SIZE_BUS;
      ar_snoop_ff  <= `CWB_SNP_ZERO_R;
      ar_domain_ff <= `CWB_DOM_NSH;
      ar_bar_ff    <= `CWB_BAR_NORMAL;
      ar_cache_ff  <= `CWB_CACHE_BAR;
      ar_lock_ff   <= `CWB_LOCK_NORMAL;
      ar_prot_ff   <= 3'h0;
    end else begin
      if (ar_valid_ff && ar_ready) begin
        ar_valid_ff <= 1'h0;
      end
      if (cmd_take && (cmd_op == `CWB_OP_BAR_RD)) begin
        ar_valid_ff  <= 1'h1;
        ar_addr_ff   <= {`CWB_ADDR_W{1'b0}};
        ar_burst_ff  <= `CWB_BURST_INCR;
        ar_len_ff    <= 8'h00;
        ar_snoop_ff  <= `CWB_SNP_ZERO_R;
        ar_size_ff   <= `CWB_SIZE_BUS;
        ar_cache_ff  <= `CWB_CACHE_BAR;
        ar_bar_ff    <= `CWB_BAR_BARRIER;
        ar_domain_ff <= cmd_domain;
        ar_lock_ff   <= `CWB_LOCK_NORMAL;
        ar_prot_ff   <= cmd_prot;
      end
    end
  end

  // Write data: one slot, so throughput is one beat per three cycles,
  // traded for every output coming straight from a flop
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ready_ff <= 1'h0;
      w_valid_ff  <= 1'h0;
      w_data_ff   <= {`CWB_DATA_W{1'b0}};
      w_strb_ff   <= {`CWB_STRB_W{1'b0}};
      w_last_ff   <= 1'h0;
      beat_cnt_ff <= 5'h00;
    end else begin
      if (w_valid_ff && w_ready) begin
        w_valid_ff <= 1'h0;
      end
      if (w_take) begin
        w_valid_ff  <= 1'h1;
        w_data_ff   <= wr_data;
        w_strb_ff   <= wr_strb;
        w_last_ff   <= (beat_cnt_ff == (beats_ff - 5'h01));
        beat_cnt_ff <= beat_cnt_ff + 5'h01;
      end
      if (state_ff == ST_IDLE) begin
        beat_cnt_ff <= 5'h00;
      end
      // Offer a slot only while beats remain and the slot is free
      wr_ready_ff <= (state_ff == ST_DATA) & ~w_take & ~(w_valid_ff & ~w_ready) &
                     ~w_valid_ff & (beat_cnt_ff < beats_ff);
    end
  end

endmodule

// [hdl/cwb_req_map.vh]
`ifndef CWB_REQ_MAP_VH
`define CWB_REQ_MAP_VH
// Bus and cache line geometry
`define CWB_ADDR_W        32
`define CWB_DATA_W        64
`define CWB_STRB_W        8
`define CWB_SIZE_BUS      3'h3
`define CWB_BEAT_LSB      3
`define CWB_BEAT_MSB      5
`define CWB_LINE_BEATS    5'h08
`define CWB_MAX_BEATS     5'h10
// Burst types
`define CWB_BURST_FIXED   2'h0
`define CWB_BURST_INCR    2'h1
`define CWB_BURST_WRAP    2'h2
// Shareability domains
`define CWB_DOM_NSH       2'h0
`define CWB_DOM_ISH       2'h1
`define CWB_DOM_OSH       2'h2
`define CWB_DOM_SYS       2'h3
// Write snoop codes and read barrier snoop code
`define CWB_SNP_WB        3'h3
`define CWB_SNP_WC        3'h2
`define CWB_SNP_ZERO      3'h0
`define CWB_SNP_ZERO_R    4'h0
// Barrier attribute, cache, lock
`define CWB_BAR_NORMAL    2'h0
`define CWB_BAR_BARRIER   2'h1
`define CWB_CACHE_BAR     4'h2
`define CWB_CACHE_MOD     4'h2
`define CWB_LOCK_NORMAL   1'h0
// Command opcodes
`define CWB_OP_WB         2'h0
`define CWB_OP_WC         2'h1
`define CWB_OP_BAR_WR     2'h2
`define CWB_OP_BAR_RD     2'h3
// Error codes
`define CWB_ERR_NONE      2'h0
`define CWB_ERR_DOMAIN    2'h1
`define CWB_ERR_LENGTH    2'h2
`define CWB_ERR_LINE      2'h3
`endif

// [tb/coherent_write_and_barrier_request_rules_tb.sv]
`timescale 1ns/1ps
`include "cwb_req_map.vh"
module coherent_write_and_barrier_request_rules_tb;
  logic        ref_clk = 1'b0;
  logic        rst, cmd_valid, cmd_wrap, wr_valid, slow, cmd_ready_ff, cmd_err_ff, wr_ready_ff;
  logic        aw_valid_ff, aw_lock_ff, w_valid_ff, w_last_ff, ar_valid_ff, ar_lock_ff;
  logic        aw_ready, w_ready, ar_ready;
  logic [31:0] cmd_addr, aw_addr_ff, ar_addr_ff, lfsr = 32'haf365903;
  logic [7:0]  aw_len_ff, ar_len_ff, w_strb_ff, wr_strb;
  logic [4:0]  cmd_beats;
  logic [1:0]  cmd_op, cmd_domain, cmd_err_code_ff, aw_burst_ff, ar_burst_ff;
  logic [1:0]  aw_domain_ff, ar_domain_ff, aw_bar_ff, ar_bar_ff;
  logic [2:0]  aw_size_ff, ar_size_ff, aw_snoop_ff, aw_prot_ff, ar_prot_ff, cmd_prot;
  logic [3:0]  ar_snoop_ff, aw_cache_ff, ar_cache_ff, aw_qos_ff, cmd_cache, cmd_qos;
  logic [63:0] w_data_ff, wr_data, aw_q[$], ar_q[$];
  logic [72:0] w_q[$];
  logic [1:0]  e_q[$];
  int          fails = 0, checks = 0, k, shr_cnt = 0;
  cwb_req_gen dut (.*);
  cwb_icn_model icn (.*);
  always #12.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic note(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmp_aw(input logic [63:0] got);
    note(aw_q.size() > 0 && got === aw_q.pop_front(), "write address request");
  endtask
  task automatic cmp_ar(input logic [63:0] got);
    note(ar_q.size() > 0 && got === ar_q.pop_front(), "read barrier request");
  endtask
  task automatic cmp_w(input logic [72:0] got);
    note(w_q.size() > 0 && got === w_q.pop_front(), "write beat");
  endtask
  task automatic cmp_err(input logic [1:0] got);
    note(e_q.size() > 0 && got === e_q.pop_front(), "refusal code");
  endtask
  // Bounded wait for command ready (0) or beat ready (1), seen at an edge
  task automatic wait_for(input bit w);
    for (int i = 0; !(w ? wr_ready_ff : cmd_ready_ff); i++) begin
      if (i > 200) begin
        fails++;
        conclude();
      end
      @(posedge ref_clk);
    end
  endtask
  // One command with its expected answer noted first, then its beats
  task automatic send(input logic [1:0] op, input logic [4:0] n, input logic wr,
                      input logic [1:0] dm);
    logic [31:0] a;
    logic [63:0] d;
    logic [1:0]  code;
    a = rnd();
    @(posedge ref_clk);
    wait_for(0);
    if (op[1]) code = `CWB_ERR_NONE;
    else if (dm == `CWB_DOM_SYS) code = `CWB_ERR_DOMAIN;
    else if (wr ? !(n inside {5'h02, 5'h04, 5'h08, 5'h10}) : (n == 5'h0 || n > 5'h10))
      code = `CWB_ERR_LENGTH;
    else if (wr ? n > 5'h08 : a[5:3] + n > 8) code = `CWB_ERR_LINE;
    else code = `CWB_ERR_NONE;
    cmd_op <= op;
    cmd_beats <= n;
    cmd_wrap <= wr;
    cmd_domain <= dm;
    cmd_addr <= a;
    cmd_cache <= a[11:8];
    cmd_prot <= a[14:12];
    cmd_qos <= a[19:16];
    cmd_valid <= 1'b1;
    if (code != `CWB_ERR_NONE) e_q.push_back(code);
    else if (op == `CWB_OP_BAR_RD) ar_q.push_back({35'h0, 8'h0, `CWB_BURST_INCR, `CWB_SIZE_BUS,
      `CWB_SNP_ZERO_R, dm, `CWB_BAR_BARRIER, `CWB_CACHE_BAR, 1'b0, a[14:12]});
    else if (op[1]) aw_q.push_back({32'h0, 8'h0, `CWB_BURST_INCR, `CWB_SIZE_BUS, `CWB_SNP_ZERO,
      dm, `CWB_BAR_BARRIER, `CWB_CACHE_BAR, 1'b0, a[14:12], a[19:16]});
    else aw_q.push_back({a[31:3], 3'h0, {3'h0, n} - 8'h01, wr ? `CWB_BURST_WRAP : `CWB_BURST_INCR,
      `CWB_SIZE_BUS, op == `CWB_OP_WB ? `CWB_SNP_WB : `CWB_SNP_WC, dm, `CWB_BAR_NORMAL,
      a[11:8] | `CWB_CACHE_MOD, 1'b0, a[14:12], a[19:16]});
    // Only accepted shareable write-lines may be tracked by the far side
    if (code == `CWB_ERR_NONE && !op[1] && dm inside {2'h1, 2'h2}) shr_cnt++;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (int i = 0; !op[1] && code == `CWB_ERR_NONE && i < n; i++) begin
      @(posedge ref_clk);
      d = {rnd(), rnd()};
      wr_data <= d;
      wr_strb <= d[7:0];
      wr_valid <= 1'b1;
      w_q.push_back({d, d[7:0], i == n - 1});
      @(posedge ref_clk);
      wait_for(1);
      wr_valid <= 1'b0;
    end
  endtask
  // Observed request words, fields in the same order as the notes
  wire [63:0] aw_got = {aw_addr_ff, aw_len_ff, aw_burst_ff, aw_size_ff, aw_snoop_ff,
                        aw_domain_ff, aw_bar_ff, aw_cache_ff, aw_lock_ff, aw_prot_ff, aw_qos_ff};
  wire [63:0] ar_got = {3'h0, ar_addr_ff, ar_len_ff, ar_burst_ff, ar_size_ff, ar_snoop_ff,
                        ar_domain_ff, ar_bar_ff, ar_cache_ff, ar_lock_ff, ar_prot_ff};
  // Watch every handshake and refusal, compare with the oldest note
  always @(posedge ref_clk) if (!rst) begin
    if (aw_valid_ff && aw_ready) cmp_aw(aw_got);
    if (ar_valid_ff && ar_ready) cmp_ar(ar_got);
    if (w_valid_ff && w_ready) cmp_w({w_data_ff, w_strb_ff, w_last_ff});
    if (cmd_err_ff) cmp_err(cmd_err_code_ff);
  end
  // Reset, boundary sweeps, then random traffic with a stalling far side
  initial begin
    {rst, cmd_valid, wr_valid, slow} = 4'h8;
    {cmd_op, cmd_addr, cmd_beats, cmd_wrap, cmd_domain, cmd_cache} = '0;
    {cmd_prot, cmd_qos, wr_data, wr_strb} = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 0; k < 18; k++) send({1'b0, k[0]}, k[4:0], 1'b1, 2'h1);
    for (k = 0; k < 18; k++) send({1'b0, k[0]}, k[4:0], 1'b0, 2'h2);
    for (k = 0; k < 16; k++) send(k[3:2], 5'h01, 1'b0, k[1:0]);
    slow <= 1'b1;
    for (k = 0; k < 40; k++) send(lfsr[1:0], lfsr[6:2], lfsr[7], lfsr[9:8]);
    @(posedge ref_clk);
    wait_for(0);
    note(aw_q.size() + ar_q.size() + w_q.size() + e_q.size() == 0, "missing answers");
    note(icn.alloc_cnt == shr_cnt, "allocation count");
    conclude();
  end
endmodule

// [tb/cwb_asserts.sv]
`timescale 1ns/1ps
`include "cwb_req_map.vh"
module cwb_chk (
  // Clock, reset and user side
  input logic        ref_clk, rst, cmd_valid, cmd_ready_ff, cmd_err_ff, wr_valid, wr_ready_ff,
  input logic [1:0]  cmd_op, cmd_domain, cmd_err_code_ff,
  input logic [2:0]  cmd_prot,
  input logic [7:0]  wr_strb, w_strb_ff,
  // Address and data channels
  input logic        aw_valid_ff, aw_lock_ff, w_valid_ff, ar_valid_ff, ar_lock_ff,
  input logic [31:0] aw_addr_ff, ar_addr_ff,
  input logic [7:0]  aw_len_ff, ar_len_ff,
  input logic [1:0]  aw_burst_ff, ar_burst_ff, aw_domain_ff, aw_bar_ff, ar_bar_ff,
  input logic [2:0]  aw_size_ff, ar_size_ff, aw_snoop_ff, aw_prot_ff,
  input logic [3:0]  aw_cache_ff, ar_cache_ff, ar_snoop_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Write-line request standing on the write address channel
  logic wl;
  assign wl = aw_valid_ff && !aw_bar_ff[0];
  sequence s_take; cmd_valid && cmd_ready_ff; endsequence
  sequence s_beat; wr_valid && wr_ready_ff; endsequence
  chk_one_answer: assert property (s_take |=> $onehot({aw_valid_ff, ar_valid_ff, cmd_err_ff}))
    else $error("command without a single answer");
  chk_sys_refused: assert property (
    s_take ##0 (!cmd_op[1] && cmd_domain == `CWB_DOM_SYS)
    |=> cmd_err_ff && cmd_err_code_ff == `CWB_ERR_DOMAIN) else $error("system domain taken");
  chk_dom_true: assert property (
    s_take ##0 (!cmd_op[1] && cmd_domain != `CWB_DOM_SYS) |=> cmd_err_ff ||
    (aw_domain_ff == $past(cmd_domain) && aw_prot_ff == $past(cmd_prot)))
    else $error("domain or prot altered");
  chk_no_system: assert property (wl |-> aw_domain_ff != `CWB_DOM_SYS)
    else $error("write-line in system domain");
  chk_wl_attr: assert property (
    wl |-> aw_burst_ff != `CWB_BURST_FIXED && aw_cache_ff[1] && !aw_lock_ff)
    else $error("write-line attributes wrong");
  chk_wrap_len: assert property (
    wl && aw_burst_ff == `CWB_BURST_WRAP |-> aw_len_ff inside {8'h01, 8'h03, 8'h07, 8'h0f})
    else $error("wrap length illegal");
  chk_wrap_fit: assert property (
    wl && aw_burst_ff == `CWB_BURST_WRAP |-> aw_len_ff < 8'h08 && aw_addr_ff[2:0] == 3'h0
    && aw_size_ff == `CWB_SIZE_BUS) else $error("wrap exceeds line or misaligned");
  chk_incr_line: assert property (
    wl && aw_burst_ff == `CWB_BURST_INCR |-> aw_len_ff < 8'h10
    && ({5'h00, aw_addr_ff[5:3]} + aw_len_ff) < 8'h08) else $error("incr crosses line");
  chk_aw_barrier: assert property (
    aw_valid_ff && aw_bar_ff[0] |-> aw_addr_ff == 32'h0 && aw_len_ff == 8'h0 && !aw_lock_ff
    && aw_burst_ff == `CWB_BURST_INCR && aw_snoop_ff == `CWB_SNP_ZERO
    && aw_size_ff == `CWB_SIZE_BUS && aw_cache_ff == `CWB_CACHE_BAR) else $error("aw barrier");
  chk_ar_barrier: assert property (
    ar_valid_ff |-> ar_bar_ff == `CWB_BAR_BARRIER && ar_addr_ff == 32'h0 && ar_len_ff == 8'h0
    && ar_burst_ff == `CWB_BURST_INCR && ar_snoop_ff == `CWB_SNP_ZERO_R && !ar_lock_ff
    && ar_size_ff == `CWB_SIZE_BUS && ar_cache_ff == `CWB_CACHE_BAR) else $error("ar barrier");
  chk_strobe_pass: assert property (
    s_beat |=> w_valid_ff && w_strb_ff == $past(wr_strb)) else $error("strobes altered");
endmodule
bind cwb_req_gen cwb_chk u_chk (.*);

// [tb/cwb_icn_model.sv]
`timescale 1ns/1ps
module cwb_icn_model (
  // Clock and reset
  input  logic       ref_clk,
  input  logic       rst,
  // Pacing and observed request
  input  logic       slow,
  input  logic       aw_valid_ff,
  input  logic [1:0] aw_domain_ff,
  input  logic [1:0] aw_bar_ff,
  // Ready answers
  output logic       aw_ready,
  output logic       w_ready,
  output logic       ar_ready
);
  logic [1:0] pace_ff;
  int         alloc_cnt;
  // Slow mode stalls three cycles in four, so no wait is endless
  always @(posedge ref_clk) begin
    pace_ff  <= rst ? 2'h0 : pace_ff + 2'h1;
    aw_ready <= !slow || pace_ff == 2'h3;
    w_ready  <= !slow || pace_ff == 2'h1;
    ar_ready <= !slow || pace_ff == 2'h2; // Barriers of any domain taken
    // Line tracking counts shareable allocations only; barriers allocate nothing
    if (rst)
      alloc_cnt <= 0;
    else if (aw_valid_ff && aw_ready && !aw_bar_ff[0] && aw_domain_ff inside {2'h1, 2'h2})
      alloc_cnt <= alloc_cnt + 1;
  end
endmodule
